// *** hw/hsp_pkg.sv ***
// package of the sorting handler port: line counts, state codes, reset values
// assumes a single 10 MHz clock domain and a synchronous active-high reset
package hsp_pkg;

    // ----------------------------------------------------------------
    // line counts
    // ----------------------------------------------------------------
    localparam int unsigned HSP_BIN_LINES  = 9;   // numbered bin lines
    localparam int unsigned HSP_POINTS_MAX = 10;  // sweep points, tenth on out-of-bins
    localparam int unsigned HSP_PT_W       = 4;   // width of a sweep point index
    localparam int unsigned HSP_SYNC_W     = 2;   // pins passed through synchroniser

    // ----------------------------------------------------------------
    // synchroniser bit positions
    // ----------------------------------------------------------------
    localparam int unsigned HSP_SYNC_TRIG  = 0;
    localparam int unsigned HSP_SYNC_LOCK  = 1;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        HSP_IDLE = 4'h1,  // waiting for a trigger
        HSP_ACQ  = 4'h2,  // analog acquisition of the current point
        HSP_CMP  = 4'h4,  // waiting for the comparison of the current point
        HSP_DONE = 4'h8   // results settled, raise the done strobe next
    } hsp_state_type;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [HSP_BIN_LINES-1:0] HSP_BIN_RST = 9'h000;
    localparam logic [HSP_PT_W-1:0]      HSP_PT_RST  = 4'h0;
    localparam logic [HSP_POINTS_MAX-1:0] HSP_FAIL_RST = 10'h000;
    localparam logic [HSP_PT_W-1:0]      HSP_NO_BIN  = 4'h0;  // bin number meaning out of bins

endpackage

// *** hw/hsp_sync.sv ***
// two-stage synchroniser for the handler input pins, one stage pair per bit
// assumes inputs are asynchronous to ref_clk_i; outputs feed ordinary logic
`timescale 1ns/1ps
module hsp_sync
    import hsp_pkg::*;
#(
    parameter int unsigned WIDTH = HSP_SYNC_W
) (
    input  wire logic             ref_clk_i,
    input  wire logic             srst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    // ----------------------------------------------------------------
    // per-bit flop pair
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] meta;

    // the first stage is read by the second stage only
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge ref_clk_i) begin
                if (srst_i) begin
                    meta[g]   <= 1'b0;
                    sync_o[g] <= 1'b0;
                end else begin
                    meta[g]   <= async_i[g];
                    sync_o[g] <= meta[g];
                end
            end
        end
    endgenerate

endmodule

// *** hw/hsp_handler_port.sv ***
// handler port of a component measurement instrument: sorting result lines,
// progress strobes, external trigger and panel lock
// assumes the measurement engine runs on ref_clk_i and reports by one-cycle pulses;
// every open-collector line is pulled low while its _oe output is high
`timescale 1ns/1ps
module hsp_handler_port
    import hsp_pkg::*;
#(
    parameter int unsigned VAL_W = 24  // width of measured values and limits
) (
    input  wire logic                      ref_clk_i,
    input  wire logic                      srst_i,
    // pins from the handler
    input  wire logic                      external_trigger_input_i,
    input  wire logic                      panel_lock_i,
    // configuration from the instrument
    input  wire logic                      external_trigger_mode_i,
    input  wire logic                      list_mode_i,
    input  wire logic                      sequential_sweep_mode_i,
    input  wire logic [HSP_PT_W-1:0]       sweep_points_i,
    input  wire logic signed [VAL_W-1:0]   main_high_limit_i,
    input  wire logic signed [VAL_W-1:0]   main_low_limit_i,
    input  wire logic signed [VAL_W-1:0]   sec_high_limit_i,
    input  wire logic signed [VAL_W-1:0]   sec_low_limit_i,
    // measurement engine
    input  wire logic                      internal_trigger_i,
    output logic                           meas_start_o,
    input  wire logic                      acq_done_i,
    input  wire logic                      cmp_done_i,
    input  wire logic signed [VAL_W-1:0]   primary_value_i,
    input  wire logic signed [VAL_W-1:0]   secondary_value_i,
    input  wire logic [HSP_PT_W-1:0]       bin_number_i,
    input  wire logic                      aux_bin_i,
    input  wire logic                      point_fail_i,
    input  wire logic                      circuit_open_i,
    output logic [HSP_PT_W-1:0]            sweep_point_o,
    // front panel keys
    input  wire logic                      key_press_i,
    output logic                           key_accept_o,
    // open-collector handler lines
    output logic [HSP_BIN_LINES-1:0]       bin_result_lines_o,
    output logic [HSP_BIN_LINES-1:0]       bin_result_lines_oe_o,
    output logic                           out_of_bins_o,
    output logic                           out_of_bins_oe_o,
    output logic                           aux_line_o,
    output logic                           aux_line_oe_o,
    output logic                           main_high_flag_o,
    output logic                           main_high_flag_oe_o,
    output logic                           main_low_flag_o,
    output logic                           main_low_flag_oe_o,
    output logic                           secondary_reject_flag_o,
    output logic                           secondary_reject_flag_oe_o,
    output logic                           alarm_o,
    output logic                           alarm_oe_o,
    output logic                           analog_done_strobe_o,
    output logic                           analog_done_strobe_oe_o,
    output logic                           measurement_done_strobe_o,
    output logic                           measurement_done_strobe_oe_o
);

    // ----------------------------------------------------------------
    // decoding helper
    // ----------------------------------------------------------------
    // one-hot of a 1-based line number; 0 selects no line
    function automatic logic [HSP_POINTS_MAX-1:0] line_sel(input logic [HSP_PT_W-1:0] num);
        logic [HSP_POINTS_MAX-1:0] v;
        v = '0;
        for (int i = 0; i < HSP_POINTS_MAX; i++) begin
            if (num == HSP_PT_W'(i + 1)) begin
                v[i] = 1'b1;
            end
        end
        return v;
    endfunction

    // ----------------------------------------------------------------
    // pin inputs
    // ----------------------------------------------------------------
    logic [HSP_SYNC_W-1:0] pin_sync;
    logic                  trig_last;
    logic                  trig_rise;
    logic                  locked;

    hsp_sync #(
        .WIDTH (HSP_SYNC_W)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .async_i   ({panel_lock_i, external_trigger_input_i}),
        .sync_o    (pin_sync)
    );

    // edge detect on the synchronised level, never on the first stage
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            trig_last <= 1'b0;
        end else begin
            trig_last <= pin_sync[HSP_SYNC_TRIG];
        end
    end

    assign trig_rise = pin_sync[HSP_SYNC_TRIG] & ~trig_last;
    assign locked    = pin_sync[HSP_SYNC_LOCK];

    // key presses pass only while the handler does not hold the lock
    assign key_accept_o = key_press_i & ~locked;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    hsp_state_type           state;
    logic [HSP_PT_W-1:0]     point;
    logic [HSP_POINTS_MAX-1:0] fail_vec;
    logic                    start;
    logic                    last_point;
    logic                    finish_list;

    // triggers arriving mid-measurement are dropped; the engine cannot overlap
    assign start       = (state == HSP_IDLE) &&
                         (external_trigger_mode_i ? trig_rise : internal_trigger_i);
    assign last_point  = ~list_mode_i || (point >= sweep_points_i - HSP_PT_W'(1));
    // a list is finished when its last point has been compared
    assign finish_list = list_mode_i && last_point;
    assign meas_start_o  = start;
    assign sweep_point_o = point;

    // state progression
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state <= HSP_IDLE;
        end else begin
            case (state)
                HSP_IDLE: begin
                    if (start) begin
                        state <= HSP_ACQ;
                    end
                end
                HSP_ACQ: begin
                    if (acq_done_i) begin
                        state <= HSP_CMP;
                    end
                end
                HSP_CMP: begin
                    if (cmp_done_i) begin
                        // sequential lists run on without a new trigger
                        if (list_mode_i && sequential_sweep_mode_i && !last_point) begin
                            state <= HSP_ACQ;
                        end else begin
                            state <= HSP_DONE;
                        end
                    end
                end
                HSP_DONE: begin
                    state <= HSP_IDLE;
                end
                default: begin
                    state <= HSP_IDLE;
                end
            endcase
        end
    end

    // sweep point index and per-point failure record
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            point    <= HSP_PT_RST;
            fail_vec <= HSP_FAIL_RST;
        end else if (start && (point == HSP_PT_RST || sequential_sweep_mode_i)) begin
            point    <= HSP_PT_RST;  // a fresh list
            fail_vec <= HSP_FAIL_RST;
        end else if (state == HSP_CMP && cmp_done_i && list_mode_i) begin
            if (point_fail_i) begin
                fail_vec <= fail_vec | line_sel(point + HSP_PT_W'(1));
            end
            point <= last_point ? HSP_PT_RST : point + HSP_PT_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // comparison result lines
    // ----------------------------------------------------------------
    logic [HSP_POINTS_MAX-1:0] bin_sel;
    logic [HSP_POINTS_MAX-1:0] fail_now;

    assign bin_sel  = line_sel(bin_number_i);
    assign fail_now = fail_vec | (point_fail_i ? line_sel(point + HSP_PT_W'(1)) : HSP_FAIL_RST);

    // results are latched on the final comparison, one cycle before the done strobe
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            bin_result_lines_oe_o      <= HSP_BIN_RST;
            out_of_bins_oe_o           <= 1'b0;
            aux_line_oe_o              <= 1'b0;
            main_high_flag_oe_o        <= 1'b0;
            main_low_flag_oe_o         <= 1'b0;
            secondary_reject_flag_oe_o <= 1'b0;
        end else if (state == HSP_CMP && cmp_done_i && !list_mode_i) begin
            bin_result_lines_oe_o      <= bin_sel[HSP_BIN_LINES-1:0];
            out_of_bins_oe_o           <= (bin_number_i == HSP_NO_BIN);
            aux_line_oe_o              <= aux_bin_i;
            main_high_flag_oe_o        <= primary_value_i > main_high_limit_i;
            main_low_flag_oe_o         <= primary_value_i < main_low_limit_i;
            secondary_reject_flag_oe_o <= (secondary_value_i > sec_high_limit_i) ||
                                          (secondary_value_i < sec_low_limit_i);
        end else if (state == HSP_CMP && cmp_done_i && finish_list) begin
            // per-point verdicts appear only when the whole list is done
            bin_result_lines_oe_o      <= fail_now[HSP_BIN_LINES-1:0];
            out_of_bins_oe_o           <= fail_now[HSP_POINTS_MAX-1];
            aux_line_oe_o              <= |fail_now;
            main_high_flag_oe_o        <= 1'b0;
            main_low_flag_oe_o         <= 1'b0;
            secondary_reject_flag_oe_o <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // progress strobes and alarm
    // ----------------------------------------------------------------
    logic seq_list;

    assign seq_list = list_mode_i && sequential_sweep_mode_i;

    // analog-done: every acquisition, except a sequential list waits for its last point
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            analog_done_strobe_oe_o <= 1'b0;
        end else if (start) begin
            analog_done_strobe_oe_o <= 1'b0;
        end else if (state == HSP_ACQ && acq_done_i && (!seq_list || last_point)) begin
            analog_done_strobe_oe_o <= 1'b1;
        end
    end

    // measurement-done: a cycle after the result lines settle, so they are valid first
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            measurement_done_strobe_oe_o <= 1'b0;
        end else if (start) begin
            measurement_done_strobe_oe_o <= 1'b0;
        end else if (state == HSP_DONE) begin
            measurement_done_strobe_oe_o <= 1'b1;
        end
    end

    // alarm follows the circuit-open detector, registered
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            alarm_oe_o <= 1'b0;
        end else begin
            alarm_oe_o <= circuit_open_i;
        end
    end

    // open-collector lines only ever pull low; the enable carries the condition
    assign bin_result_lines_o        = HSP_BIN_RST;
    assign out_of_bins_o             = 1'b0;
    assign aux_line_o                = 1'b0;
    assign main_high_flag_o          = 1'b0;
    assign main_low_flag_o           = 1'b0;
    assign secondary_reject_flag_o   = 1'b0;
    assign alarm_o                   = 1'b0;
    assign analog_done_strobe_o      = 1'b0;
    assign measurement_done_strobe_o = 1'b0;

endmodule

// *** bench/hsp_port_checker.sv ***
// checker for the handler port: strobe order, alarm, panel lock
// assumes it is bound to hsp_handler_port; one clock, sync reset
`timescale 1ns/1ps
module hsp_port_checker (
    input wire logic       ref_clk_i,
    input wire logic       srst_i,
    input wire logic       panel_lock_i,
    input wire logic       key_press_i,
    input wire logic       key_accept_o,
    input wire logic       circuit_open_i,
    input wire logic       alarm_oe_o,
    input wire logic       acq_done_i,
    input wire logic       cmp_done_i,
    input wire logic       meas_start_o,
    input wire logic       analog_done_strobe_oe_o,
    input wire logic       measurement_done_strobe_oe_o,
    input wire logic [8:0] bin_result_lines_oe_o
);
    // ----------------------------------------------------------------
    // properties, one clock domain
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    // lock needs four samples since the pin passes a synchroniser
    a_alarm_tracks_open: assert property (
        !srst_i |=> alarm_oe_o == $past(circuit_open_i)) else $error("alarm late");
    a_lock_blocks_keys: assert property (
        panel_lock_i [*4] ##0 key_press_i |-> !key_accept_o) else $error("key passed lock");
    a_unlock_keys_pass: assert property (
        !panel_lock_i [*4] ##0 key_press_i |-> key_accept_o) else $error("key lost");
    a_start_clears_strobes: assert property (
        meas_start_o |=> !analog_done_strobe_oe_o && !measurement_done_strobe_oe_o)
        else $error("strobes kept after start");
    a_analog_has_cause: assert property (
        $rose(analog_done_strobe_oe_o) |-> $past(acq_done_i)) else $error("analog strobe");
    a_done_has_cause: assert property (
        $rose(measurement_done_strobe_oe_o) |-> $past(cmp_done_i, 2))
        else $error("done strobe timing");
    a_analog_before_done: assert property (
        $rose(measurement_done_strobe_oe_o) |-> analog_done_strobe_oe_o)
        else $error("done without analog");
    a_results_hold_done: assert property (
        measurement_done_strobe_oe_o && $past(measurement_done_strobe_oe_o)
        |-> $stable(bin_result_lines_oe_o)) else $error("results moved");
    c_done: cover property ($rose(measurement_done_strobe_oe_o));
    c_analog: cover property ($rose(analog_done_strobe_oe_o));
    c_locked_key: cover property (panel_lock_i && key_press_i);
endmodule

// *** bench/hsp_handler_model.sv ***
// model of the part handler: trigger pulses, key lock, result sampling
// assumes the bench requests triggers only while the pin is low
`timescale 1ns/1ps
module hsp_handler_model (
    input  wire logic        ref_clk_i,
    input  wire logic        srst_i,
    input  wire logic        trig_req_i,
    input  wire logic        lock_req_i,
    input  wire logic        done_oe_i,
    input  wire logic [10:0] lines_oe_i,
    output logic             external_trigger_input_o,
    output logic             lock_o,
    output logic [10:0]      seen_o
);
    logic [3:0] width_cnt;
    logic       done_q;
    // pulse of 12 cycles, above the 1 us minimum width
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) width_cnt <= 4'h0;
        else if (trig_req_i) width_cnt <= 4'hc;
        else if (width_cnt != 4'h0) width_cnt <= width_cnt - 4'h1;
    end
    assign external_trigger_input_o = (width_cnt != 4'h0);
    // lock and sampling; results are taken only at measurement done
    always_ff @(posedge ref_clk_i) begin
        lock_o <= lock_req_i;
        done_q <= done_oe_i;
        if (srst_i) seen_o <= 11'h000;
        else if (done_oe_i && !done_q) seen_o <= lines_oe_i;
    end
endmodule

// *** bench/hsp_handler_port_bench.sv ***
// self-checking bench of the handler port with a handler model
// assumes the engine side is played by the bench tasks below
`timescale 1ns/1ps
module hsp_handler_port_bench;
    import hsp_pkg::*;
    localparam logic signed [23:0] HI = 24'sh0003e8, LO = -24'sh0003e8;
    localparam logic signed [23:0] SH = 24'sh000032, SL = -24'sh000032;
    logic ref_clk_i, srst_i, ext_mode, list_mode, seq_mode, itrig, acq, cmp, aux_in;
    logic pfail, copen, key, trig_req, lock_req, ext_pin, lock_pin, start, kacc;
    logic out_oe, aux_oe, hi_oe, lo_oe, secondary_reject_flag_oe, alm_oe, ana_oe, done_oe;
    logic [3:0] npts, bin_no, spt;
    logic signed [23:0] pval, sval;
    logic [8:0] bins_oe;
    logic [16:0] drv;  // levels of the open-collector pins themselves
    logic [10:0] seen;
    int bad_count, num_checks;
    hsp_handler_port dut (
        .ref_clk_i (ref_clk_i), .srst_i (srst_i), .external_trigger_input_i (ext_pin),
        .panel_lock_i (lock_pin), .external_trigger_mode_i (ext_mode),
        .list_mode_i (list_mode), .sequential_sweep_mode_i (seq_mode), .sweep_points_i (npts),
        .main_high_limit_i (HI), .main_low_limit_i (LO), .sec_high_limit_i (SH),
        .sec_low_limit_i (SL), .internal_trigger_i (itrig), .meas_start_o (start),
        .acq_done_i (acq), .cmp_done_i (cmp), .primary_value_i (pval),
        .secondary_value_i (sval), .bin_number_i (bin_no), .aux_bin_i (aux_in),
        .point_fail_i (pfail), .circuit_open_i (copen), .sweep_point_o (spt),
        .key_press_i (key), .key_accept_o (kacc), .bin_result_lines_o (drv[8:0]),
        .bin_result_lines_oe_o (bins_oe), .out_of_bins_o (drv[9]), .out_of_bins_oe_o (out_oe),
        .aux_line_o (drv[10]), .aux_line_oe_o (aux_oe), .main_high_flag_o (drv[11]),
        .main_high_flag_oe_o (hi_oe), .main_low_flag_o (drv[12]), .main_low_flag_oe_o (lo_oe),
        .secondary_reject_flag_o (drv[13]), .secondary_reject_flag_oe_o (secondary_reject_flag_oe),
        .alarm_o (drv[14]), .alarm_oe_o (alm_oe), .analog_done_strobe_o (drv[15]),
        .analog_done_strobe_oe_o (ana_oe), .measurement_done_strobe_o (drv[16]),
        .measurement_done_strobe_oe_o (done_oe));
    hsp_handler_model hdl (
        .ref_clk_i (ref_clk_i), .srst_i (srst_i), .trig_req_i (trig_req),
        .lock_req_i (lock_req), .done_oe_i (done_oe), .lines_oe_i ({aux_oe, out_oe, bins_oe}),
        .external_trigger_input_o (ext_pin), .lock_o (lock_pin), .seen_o (seen));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [13:0] lines();
        return {secondary_reject_flag_oe, lo_oe, hi_oe, aux_oe, out_oe, bins_oe};
    endfunction
    // one engine pulse; outputs have settled when it returns
    task automatic step(input logic a, input logic c);
        @(posedge ref_clk_i);
        acq <= a;
        cmp <= c;
        @(posedge ref_clk_i);
        acq <= 1'b0;
        cmp <= 1'b0;
        #1;
    endtask
    // the pin must sit low a while so the handler gives a clean rising edge
    task automatic trigger_ext();
        int n;
        repeat (16) @(posedge ref_clk_i);
        trig_req <= 1'b1;
        @(posedge ref_clk_i) trig_req <= 1'b0;
        for (n = 0; n < 20 && start !== 1'b1; n++) @(negedge ref_clk_i);
        if (n == 20) begin
            chk("start timeout", 14'h0001, 14'h0000);
            end_of_test();
        end
        @(posedge ref_clk_i);
        #1;
        chk("strobes cleared", 14'h0000, {12'h000, ana_oe, done_oe});
    endtask
    task automatic finish_meas(input logic [13:0] exp);
        chk("done early", 14'h0000, {13'h0000, done_oe});
        @(posedge ref_clk_i);
        #1;
        chk("done raised", 14'h0001, {13'h0000, done_oe});
        @(posedge ref_clk_i);
        #1;
        chk("handler sample", {3'b000, exp[10:0]}, {3'b000, seen});
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_bins();
        logic [13:0] exp;
        for (int i = 0; i < 10; i++) begin
            @(posedge ref_clk_i);
            list_mode <= 1'b0;
            bin_no <= i[3:0];
            aux_in <= i[0];
            pval <= (i % 3 == 0) ? HI + 24'sh000001 : (i % 3 == 1) ? LO - 24'sh000001 : HI;
            sval <= (i % 4 == 1) ? SH + 24'sh000001 : i[0] ? SL - 24'sh000001 : 24'sh000000;
            exp = {i[0], i % 3 == 1, i % 3 == 0, i[0], i == 0, 9'h000};
            if (i != 0) exp[i-1] = 1'b1;
            trigger_ext();
            step(1'b1, 1'b0);
            chk("analog strobe", 14'h0001, {13'h0000, ana_oe});
            step(1'b0, 1'b1);
            chk("bin lines", exp, lines());
            finish_meas(exp);
        end
    endtask
    task automatic t_list(input int n, input logic [9:0] fails, input logic seq);
        @(posedge ref_clk_i);
        list_mode <= 1'b1;
        seq_mode <= seq;
        npts <= n[3:0];
        if (seq) trigger_ext();
        for (int p = 0; p < n; p++) begin
            if (!seq) trigger_ext();
            step(1'b1, 1'b0);
            chk("point strobes", {12'h000, !seq || p == n - 1, 1'b0},
                {12'h000, ana_oe, done_oe});
            @(posedge ref_clk_i);
            pfail <= fails[p];
            step(1'b0, 1'b1);
            chk("sweep point", (p == n - 1) ? 14'h0000 : 14'(p + 1), {10'h000, spt});
            if (!seq && p < n - 1) finish_meas(14'h0000);
        end
        chk("list lines", {3'b000, |fails, fails}, lines());
        finish_meas({3'b000, |fails, fails});
    endtask
    task automatic t_pins();
        for (int v = 1; v >= 0; v--) begin
            @(posedge ref_clk_i);
            lock_req <= v[0];
            copen <= v[0];
            key <= 1'b1;
            repeat (6) @(posedge ref_clk_i);
            #1;
            chk("key accept", {13'h0000, ~v[0]}, {13'h0000, kacc});
            chk("alarm line", {13'h0000, v[0]}, {13'h0000, alm_oe});
            chk("pin drive", 14'h0000, {13'h0000, |drv});
        end
        @(posedge ref_clk_i) key <= 1'b0;
    endtask
    // internal mode: a pin pulse is refused, the engine pulse starts a bin measurement
    task automatic t_internal();
        @(posedge ref_clk_i);
        ext_mode <= 1'b0;
        list_mode <= 1'b0;
        trig_req <= 1'b1;
        @(posedge ref_clk_i) trig_req <= 1'b0;
        repeat (5) begin
            @(negedge ref_clk_i);
            chk("pin start", 14'h0000, {13'h0000, start});
        end
        @(posedge ref_clk_i) itrig <= 1'b1;
        #1;
        chk("engine start", 14'h0001, {13'h0000, start});
        @(posedge ref_clk_i) itrig <= 1'b0;
        step(1'b1, 1'b0);
        step(1'b0, 1'b1);
        chk("internal lines", 14'h2d00, lines());
        finish_meas(14'h2d00);
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {srst_i, ext_mode} = 2'b11;
        {list_mode, seq_mode, itrig, acq, cmp, aux_in, pfail, copen, key} = 9'h000;
        {trig_req, lock_req, npts, bin_no} = 10'h000;
        {pval, sval} = 48'h000000000000;
        repeat (16) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        t_bins();
        t_list(10, 10'h202, 1'b1);
        t_list(3, 10'h000, 1'b1);
        t_list(2, 10'h002, 1'b0);
        t_pins();
        t_internal();
        end_of_test();
    end
endmodule
bind hsp_handler_port hsp_port_checker u_chk (
    .ref_clk_i (ref_clk_i), .srst_i (srst_i), .panel_lock_i (panel_lock_i),
    .key_press_i (key_press_i), .key_accept_o (key_accept_o),
    .circuit_open_i (circuit_open_i), .alarm_oe_o (alarm_oe_o),
    .acq_done_i (acq_done_i), .cmp_done_i (cmp_done_i), .meas_start_o (meas_start_o),
    .analog_done_strobe_oe_o (analog_done_strobe_oe_o),
    .measurement_done_strobe_oe_o (measurement_done_strobe_oe_o),
    .bin_result_lines_oe_o (bin_result_lines_oe_o));
